/* File: dv/rsf_ratio_select_asserts.sv */
// Purpose: port-level checks on the ratio source selector
// Assumes: zero-wait apb, LOSS_WAIT counted in divided-reference ticks
// Notes:   hold bounds leave slack for tick alignment
`timescale 1ns/1ps
module rsf_ratio_select_asserts #(
  parameter int LOSS_WAIT = 8
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        freq_ref_in,
  input wire logic [31:0] dpll_ratio,
  input wire logic [31:0] frac_value,
  input wire logic        frac_is_dynamic,
  input wire logic [31:0] effective_ratio,
  input wire logic        ratio_wide_fmt,
  input wire logic        pll_unlock_hold,
  input wire logic        ref_present,
  input wire logic        divided_timing_ref
);
  localparam int HOLD_LO = LOSS_WAIT * 4 - 12;
  localparam int HOLD_HI = LOSS_WAIT * 4 + 8;
  localparam int ABS_LIM = 1024 * 4 + 64;
  logic [13:0] quiet_r;
  logic        ref_q_r;
  // edge distance counter, saturates so a long quiet spell cannot wrap
  always_ff @(posedge core_clk) begin
    ref_q_r <= freq_ref_in;
    if (!reset_n || freq_ref_in != ref_q_r) quiet_r <= '0;
    else if (quiet_r != 14'h3fff) quiet_r <= quiet_r + 14'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_pready_zero: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h2c |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  chk_tick_period: assert property (divided_timing_ref
    |=> !divided_timing_ref [*3] ##1 divided_timing_ref)
    else $error("tick period wrong");
  chk_static_value: assert property (!frac_is_dynamic && $past(!frac_is_dynamic)
    && $stable(effective_ratio) |-> frac_value == effective_ratio)
    else $error("static value not effective ratio");
  chk_dynamic_value: assert property (frac_is_dynamic && $past(frac_is_dynamic)
    && $stable(dpll_ratio) |-> frac_value == dpll_ratio)
    else $error("dynamic value not pll ratio");
  chk_hold_length: assert property ($rose(pll_unlock_hold)
    |-> pll_unlock_hold [*8] ##[HOLD_LO:HOLD_HI] !pll_unlock_hold)
    else $error("hold length wrong");
  // hold is registered from the cycle before, so a returning reference may overlap it once
  chk_hold_absent: assert property (pll_unlock_hold
    |-> !$past(ref_present) && frac_is_dynamic)
    else $error("hold while present or static");
  chk_wide_absent: assert property (pll_unlock_hold |-> !ratio_wide_fmt)
    else $error("wide format while reference absent");
  chk_wide_static: assert property (!frac_is_dynamic && $past(!frac_is_dynamic)
    |-> !ratio_wide_fmt)
    else $error("wide format in static mode");
  chk_absent_window: assert property (quiet_r > ABS_LIM |-> !ref_present)
    else $error("presence kept without edges");
endmodule : rsf_ratio_select_asserts

/* File: dv/rsf_ref_model.sv */
// Purpose: frequency reference source at the far side of the selector
// Assumes: period unrelated to core_clk
// Notes:   stands low while stopped so presence must really drop
`timescale 1ns/1ps
module rsf_ref_model #(
  parameter int HALF_NS = 730
) (
  input  wire logic run,
  output logic      freq_ref_in
);
  initial begin
    freq_ref_in = 1'b0;
    forever begin
      #(HALF_NS);
      freq_ref_in = run ? ~freq_ref_in : 1'b0;
    end
  end
endmodule : rsf_ref_model

/* File: dv/test_rsf_ratio_select.sv */
// Purpose: self-checking bench for the ratio source selector
// Assumes: LOSS_WAIT shortened to keep the run brief
// Notes:   ratios keep low nibble clear so scaling never truncates
`timescale 1ns/1ps
module test_rsf_ratio_select;
  localparam int LOSS_WAIT = 8;
  logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        aux_control_pin = 0, ref_run = 0, e, src;
  logic [7:0]  paddr = 8'h00;
  logic [1:0]  mode_pins = 2'h0;
  logic [31:0] pwdata = '0, dpll_ratio = '0, prdata, frac_value, effective_ratio, q;
  logic [31:0] slot [4];
  logic        pready, pslverr, frac_is_dynamic, ratio_wide_fmt, pll_unlock_hold;
  logic        ref_present, divided_timing_ref, freq_ref_in;
  int          errors = 0, checked = 0, i, n;
  always #50 core_clk = ~core_clk;
  rsf_ref_model u_ref (.run(ref_run), .freq_ref_in(freq_ref_in));
  rsf_ratio_select #(.LOSS_WAIT(LOSS_WAIT)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_pins(mode_pins), .aux_control_pin(aux_control_pin), .freq_ref_in(freq_ref_in),
    .dpll_ratio(dpll_ratio), .frac_value(frac_value), .frac_is_dynamic(frac_is_dynamic),
    .effective_ratio(effective_ratio), .ratio_wide_fmt(ratio_wide_fmt),
    .pll_unlock_hold(pll_unlock_hold), .ref_present(ref_present),
    .divided_timing_ref(divided_timing_ref));
  task automatic end_sim();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; leaves just after one
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge core_clk);
    penable <= 1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 16);
    if (k >= 16) errors++;
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge core_clk);
  endtask : apb
  task automatic cfg(input logic [1:0] m, input logic [1:0] alt, input logic s,
                     input logic [1:0] sc);
    apb(1, rsf_pkg::OFS_MODE0 + {4'h0, m, 2'b00}, {27'h0, s, alt, sc});
  endtask : cfg
  task automatic glb(input logic w, input logic [2:0] f);
    apb(1, rsf_pkg::OFS_GLOBAL, {28'h0, f, w});
  endtask : glb
  function automatic logic [31:0] eff(input logic [31:0] r, input logic on, input logic [1:0] s);
    return on ? r >> (32'(s) + 1) : r;
  endfunction : eff
  // pins pass synchronisers and a registered slot read before outputs settle
  task automatic expect_out(input logic [31:0] er, input logic dyn, input logic wide);
    // a fresh pll ratio each time, so a frozen dynamic path cannot pass
    dpll_ratio <= $urandom();
    repeat (10) @(posedge core_clk);
    chk(effective_ratio, er);
    chk({31'h0, frac_is_dynamic}, {31'h0, dyn});
    chk(frac_value, dyn ? dpll_ratio : er);
    chk({31'h0, ratio_wide_fmt}, {31'h0, wide});
  endtask : expect_out
  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    end_sim();
  end
  initial begin
    void'($urandom(99021));
    repeat (2) @(posedge core_clk);
    reset_n <= 1;
    dpll_ratio <= $urandom();
    @(posedge core_clk);
    apb(0, rsf_pkg::OFS_RATIO0, '0);
    chk(q, rsf_pkg::RATIO_RESET);
    apb(0, rsf_pkg::OFS_GLOBAL, '0);
    chk(q, 32'h0000_0000);
    chk({31'h0, ratio_wide_fmt}, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      slot[i] = ($urandom() | 32'h0000_1000) & 32'hffff_fff0;
      apb(1, rsf_pkg::OFS_RATIO0 + 8'(4 * i), slot[i]);
    end
    for (i = 0; i < 4; i++) begin
      apb(0, rsf_pkg::OFS_RATIO0 + 8'(4 * i), '0);
      chk(q, slot[i]);
    end
    apb(0, 8'h40, '0);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    apb(1, rsf_pkg::OFS_EFF_RATIO, $urandom());
    for (i = 0; i < 4; i++) begin
      src = 1'($urandom());
      cfg(2'(i), 2'(i), src, 2'($urandom()));
      mode_pins <= 2'(i);
      expect_out(slot[i], src, 0);
    end
    apb(0, rsf_pkg::OFS_EFF_RATIO, '0);
    chk(q, slot[3]);
    glb(0, rsf_pkg::AUXF_SCALER_EN);
    aux_control_pin <= 1;
    for (i = 0; i < 4; i++) begin
      cfg(3, 3, 0, 2'(i));
      expect_out(eff(slot[3], 1, 2'(i)), 0, 0);
    end
    aux_control_pin <= 0;
    expect_out(slot[3], 0, 0);
    apb(0, rsf_pkg::OFS_RATIO0 + 8'h0c, '0);
    chk(q, slot[3]);
    glb(1, rsf_pkg::AUXF_SRC_SEL);
    cfg(3, 3, 0, 0);
    aux_control_pin <= 1;
    expect_out(slot[3], 1, 1);
    aux_control_pin <= 0;
    expect_out(slot[3], 0, 0);
    cfg(0, 1, 1, 0);
    mode_pins <= 0;
    aux_control_pin <= 1;
    expect_out(slot[0], 0, 0);
    ref_run <= 1;
    for (n = 0; n < 300 && ref_present !== 1'b1; n++) @(posedge core_clk);
    expect_out(slot[1], 1, 1);
    apb(0, rsf_pkg::OFS_STATUS, '0);
    chk(q & 32'h0000_01ff, 32'h0000_0097);
    glb(1, rsf_pkg::AUXF_AUTO_DIS);
    expect_out(slot[0], 1, 1);
    aux_control_pin <= 0;
    expect_out(slot[1], 1, 1);
    ref_run <= 0;
    for (n = 0; n < 6000 && pll_unlock_hold !== 1'b1; n++) @(posedge core_clk);
    chk({31'h0, n > 4000 && n < 6000}, 32'h0000_0001);
    for (n = 0; n < 100 && pll_unlock_hold !== 1'b0; n++) @(posedge core_clk);
    expect_out(slot[0], 0, 0);
    mode_pins <= 3;
    aux_control_pin <= 1;
    expect_out(slot[3], 0, 0);
    end_sim();
  end
endmodule : test_rsf_ratio_select
bind rsf_ratio_select rsf_ratio_select_asserts #(.LOSS_WAIT(LOSS_WAIT)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .freq_ref_in(freq_ref_in),
  .dpll_ratio(dpll_ratio), .frac_value(frac_value), .frac_is_dynamic(frac_is_dynamic),
  .effective_ratio(effective_ratio), .ratio_wide_fmt(ratio_wide_fmt),
  .pll_unlock_hold(pll_unlock_hold), .ref_present(ref_present),
  .divided_timing_ref(divided_timing_ref));

/* File: hdl/rsf_pkg.sv */
// Purpose: shared constants and types for the fractional-N ratio source selector
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   mode configuration and status travel as packed structs
package rsf_pkg;

  localparam int RATIO_W         = 32;
  localparam int SLOT_N          = 4;
  localparam int SLOT_W          = 2;
  localparam int ADDR_W          = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RATIO0    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE0     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_EFF_RATIO = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FRAC_VAL  = 8'h2C;

  // mode word field positions
  localparam int MODE_SCALE_LSB  = 0;
  localparam int MODE_ALT_LSB    = 2;
  localparam int MODE_SRC_BIT    = 4;
  // global word field positions
  localparam int GLB_WIDE_BIT    = 0;
  localparam int GLB_AUXF_LSB    = 1;

  // auxiliary pin function codes
  localparam logic [2:0] AUXF_SCALER_EN   = 3'h3;
  localparam logic [2:0] AUXF_AUTO_DIS    = 3'h4;
  localparam logic [2:0] AUXF_SRC_SEL     = 3'h6;

  // reset values
  localparam logic [RATIO_W-1:0] RATIO_RESET  = 32'h0010_0000;
  localparam logic               WIDE_RESET   = 1'b0;
  localparam logic [2:0]         AUXF_RESET   = 3'h0;

  // timing: divided reference is core_clk / REF_DIV; core_clk 10 MHz
  localparam int CORE_CLK_HZ        = 10_000_000;
  localparam int REF_DIV            = 4;
  localparam int PRESENCE_WIN_TICKS = 1024;
  localparam int LOSS_WAIT_TICKS    = 8_388_608;
  localparam int TICK_CNT_W         = 24;

  typedef struct packed {
    logic             frac_src_dyn;
    logic [SLOT_W-1:0] alt_ratio_pointer;
    logic [1:0]       ratio_scale_sel;
  } rsf_mode_cfg_s;

  localparam rsf_mode_cfg_s MODE_RESET = '{frac_src_dyn: 1'b0, alt_ratio_pointer: 2'h0,
                                           ratio_scale_sel: 2'h0};

  typedef struct packed {
    logic [2:0] src_state;
    logic       scaler_en;
    logic       wide_active;
    logic       unlock_hold;
    logic       auto_active;
    logic       dynamic_sel;
    logic       ref_present;
  } rsf_status_s;

  typedef enum logic [2:0] {
    SRC_STATIC  = 3'b001,
    SRC_DYNAMIC = 3'b010,
    SRC_HOLD    = 3'b100
  } rsf_src_state_e;

endpackage : rsf_pkg

/* File: hdl/rsf_ratio_select.sv */
// Purpose: picks the user ratio, applies scaler and format, selects fractional-N source
// Assumes: mode and aux pins and the frequency reference arrive asynchronously
// Notes:
// Notes on behaviour
// - four shared slots; mode pins choose slot
// - wide format is 20 integer, 12 fraction
// - wide format only when enabled, hybrid only
// - auto mode, reference absent: always 12.20
// - scaler shifts selected ratio, slots untouched
// - scale codes give 1/2,1/4,1/8,1/16
// - scaler enabled only by aux pin
// - effective ratio is ratio times scale
// - fractional value: static or dynamic source
// - manual source from per-mode parameter
// - aux pin may override manual source
// - auto: dynamic while present, else static
// - on loss, hold unlocked for loss wait, then static
// - auto slot: pointer while dynamic or in hold, else own
// - auto enabled when pointer differs from slot
// - auto ignores the manual source parameter
// - aux pin may disable auto selection
// - default format is 12 integer, 20 fraction
// - aux function 011: pin high enables scaler
// - aux function 100: pin high disables auto
// - aux function 110: pin picks source manually
`timescale 1ns/1ps
module rsf_ratio_select #(
  parameter int LOSS_WAIT = rsf_pkg::LOSS_WAIT_TICKS
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [rsf_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // pins
  input  wire logic [1:0]                    mode_pins,
  input  wire logic                          aux_control_pin,
  input  wire logic                          freq_ref_in,
  // digital pll dynamic ratio
  input  wire logic [rsf_pkg::RATIO_W-1:0]   dpll_ratio,
  // to the synthesizer
  output logic      [rsf_pkg::RATIO_W-1:0]   frac_value,
  output logic                               frac_is_dynamic,
  output logic      [rsf_pkg::RATIO_W-1:0]   effective_ratio,
  output logic                               ratio_wide_fmt,
  output logic                               pll_unlock_hold,
  output logic                               ref_present,
  output logic                               divided_timing_ref
);

  rsf_pkg::rsf_mode_cfg_s    mode_cfg_r [rsf_pkg::SLOT_N];
  logic                      wide_ratio_format_sel_r;
  logic [2:0]                aux_pin_function_cfg_r;
  logic [2:0]                mode0_sync_r, mode1_sync_r, aux_sync_r, ref_sync_r;
  logic [1:0]                mode_r;
  logic                      aux_r;
  logic                      ref_level_r;
  logic [$clog2(rsf_pkg::REF_DIV)-1:0] div_cnt_r;
  logic [rsf_pkg::TICK_CNT_W-1:0]      win_cnt_r;
  logic [rsf_pkg::TICK_CNT_W-1:0]      loss_cnt_r;
  rsf_pkg::rsf_src_state_e   state_r, state_nxt;
  logic [rsf_pkg::RATIO_W-1:0] slot_ratio, bus_ratio, scaled_ratio;
  logic [rsf_pkg::SLOT_W-1:0]  sel_slot;
  rsf_pkg::rsf_mode_cfg_s    cur_cfg;
  rsf_pkg::rsf_status_s      status;
  logic                      bus_wr, addr_ratio, addr_mode, mapped;
  logic                      auto_active, scaler_en, manual_dyn, dyn_sel, wide_active;
  logic                      ref_edge;

  localparam logic [rsf_pkg::TICK_CNT_W-1:0] WIN_LAST =
    rsf_pkg::TICK_CNT_W'(rsf_pkg::PRESENCE_WIN_TICKS - 1);
  localparam logic [rsf_pkg::TICK_CNT_W-1:0] LOSS_LAST = rsf_pkg::TICK_CNT_W'(LOSS_WAIT - 1);
  localparam logic [$clog2(rsf_pkg::REF_DIV)-1:0] DIV_LAST =
    ($clog2(rsf_pkg::REF_DIV))'(rsf_pkg::REF_DIV - 1);

  // apb decode; every access completes with no wait state
  assign bus_wr     = psel && penable && pwrite;
  assign addr_ratio = (paddr[7:4] == rsf_pkg::OFS_RATIO0[7:4]) && (paddr[1:0] == 2'b00);
  assign addr_mode  = (paddr[7:4] == rsf_pkg::OFS_MODE0[7:4]) && (paddr[1:0] == 2'b00);
  assign mapped     = addr_ratio || addr_mode || (paddr == rsf_pkg::OFS_GLOBAL)
                   || (paddr == rsf_pkg::OFS_STATUS) || (paddr == rsf_pkg::OFS_EFF_RATIO)
                   || (paddr == rsf_pkg::OFS_FRAC_VAL);
  assign pready     = psel && penable;
  assign pslverr    = psel && penable && !mapped;

  // slot read-back address is already stable in the setup phase
  rsf_ratio_store u_store (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (bus_wr && addr_ratio),
    .wr_slot   (paddr[3:2]),
    .wr_data   (pwdata),
    .rd_slot_a (sel_slot),
    .rd_data_a (slot_ratio),
    .rd_slot_b (paddr[3:2]),
    .rd_data_b (bus_ratio)
  );

  genvar g;
  generate
    for (g = 0; g < rsf_pkg::SLOT_N; g++) begin : g_mode
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          mode_cfg_r[g] <= rsf_pkg::MODE_RESET;
        end else if (bus_wr && addr_mode && (paddr[3:2] == rsf_pkg::SLOT_W'(g))) begin
          mode_cfg_r[g] <= pwdata[rsf_pkg::MODE_SRC_BIT:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wide_ratio_format_sel_r <= rsf_pkg::WIDE_RESET;
      aux_pin_function_cfg_r  <= rsf_pkg::AUXF_RESET;
    end else if (bus_wr && (paddr == rsf_pkg::OFS_GLOBAL)) begin
      wide_ratio_format_sel_r <= pwdata[rsf_pkg::GLB_WIDE_BIT];
      aux_pin_function_cfg_r  <= pwdata[rsf_pkg::GLB_AUXF_LSB +: 3];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (addr_ratio) begin
        prdata = bus_ratio;
      end else if (addr_mode) begin
        prdata = {27'h000_0000, mode_cfg_r[paddr[3:2]]};
      end else if (paddr == rsf_pkg::OFS_GLOBAL) begin
        prdata = {28'h000_0000, aux_pin_function_cfg_r, wide_ratio_format_sel_r};
      end else if (paddr == rsf_pkg::OFS_STATUS) begin
        prdata = {23'h00_0000, status};
      end else if (paddr == rsf_pkg::OFS_EFF_RATIO) begin
        prdata = effective_ratio;
      end else if (paddr == rsf_pkg::OFS_FRAC_VAL) begin
        prdata = frac_value;
      end
    end
  end

  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode0_sync_r <= 3'h0;
      mode1_sync_r <= 3'h0;
      aux_sync_r   <= 3'h0;
      ref_sync_r   <= 3'h0;
      mode_r       <= 2'h0;
      aux_r        <= 1'b0;
      ref_level_r  <= 1'b0;
    end else begin
      mode0_sync_r <= {mode0_sync_r[1:0], mode_pins[0]};
      mode1_sync_r <= {mode1_sync_r[1:0], mode_pins[1]};
      aux_sync_r   <= {aux_sync_r[1:0], aux_control_pin};
      ref_sync_r   <= {ref_sync_r[1:0], freq_ref_in};
      if (mode0_sync_r[2] == mode0_sync_r[1]) mode_r[0] <= mode0_sync_r[2];
      if (mode1_sync_r[2] == mode1_sync_r[1]) mode_r[1] <= mode1_sync_r[2];
      if (aux_sync_r[2] == aux_sync_r[1]) aux_r <= aux_sync_r[2];
      if (ref_sync_r[2] == ref_sync_r[1]) ref_level_r <= ref_sync_r[2];
    end
  end

  assign ref_edge = (ref_sync_r[2] == ref_sync_r[1]) && (ref_sync_r[2] != ref_level_r);

  // divided timing reference as a one-cycle enable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_cnt_r          <= '0;
      divided_timing_ref <= 1'b0;
    end else begin
      divided_timing_ref <= (div_cnt_r == DIV_LAST);
      div_cnt_r          <= (div_cnt_r == DIV_LAST) ? '0 : div_cnt_r + 1'b1;
    end
  end

  // presence: any edge inside the window keeps the reference present
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      win_cnt_r   <= '0;
      ref_present <= 1'b0;
    end else if (ref_edge) begin
      win_cnt_r   <= '0;
      ref_present <= 1'b1;
    end else if (divided_timing_ref) begin
      if (win_cnt_r == WIN_LAST) begin
        ref_present <= 1'b0;
      end else begin
        win_cnt_r <= win_cnt_r + 1'b1;
      end
    end
  end

  assign cur_cfg     = mode_cfg_r[mode_r];
  assign auto_active = (cur_cfg.alt_ratio_pointer != mode_r)
    && !((aux_pin_function_cfg_r == rsf_pkg::AUXF_AUTO_DIS) && aux_r);
  assign scaler_en   = (aux_pin_function_cfg_r == rsf_pkg::AUXF_SCALER_EN) && aux_r;
  assign manual_dyn  = (aux_pin_function_cfg_r == rsf_pkg::AUXF_SRC_SEL) ? aux_r
                     : cur_cfg.frac_src_dyn;

  // automatic source tracking; hold keeps the dynamic path while unlocked
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rsf_pkg::SRC_STATIC: begin
        if (auto_active && ref_present) state_nxt = rsf_pkg::SRC_DYNAMIC;
      end
      rsf_pkg::SRC_DYNAMIC: begin
        if (!auto_active) state_nxt = rsf_pkg::SRC_STATIC;
        else if (!ref_present) state_nxt = rsf_pkg::SRC_HOLD;
      end
      rsf_pkg::SRC_HOLD: begin
        if (!auto_active) state_nxt = rsf_pkg::SRC_STATIC;
        else if (ref_present) state_nxt = rsf_pkg::SRC_DYNAMIC;
        else if (divided_timing_ref && (loss_cnt_r == LOSS_LAST))
          state_nxt = rsf_pkg::SRC_STATIC;
      end
      default: state_nxt = rsf_pkg::SRC_STATIC;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= rsf_pkg::SRC_STATIC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      loss_cnt_r <= '0;
    end else if (state_r != rsf_pkg::SRC_HOLD) begin
      loss_cnt_r <= '0;
    end else if (divided_timing_ref) begin
      loss_cnt_r <= loss_cnt_r + 1'b1;
    end
  end

  // manual mode ignores the pointer; auto mode ignores the manual source
  assign dyn_sel  = auto_active ? (state_r != rsf_pkg::SRC_STATIC)
                                : manual_dyn;
  assign sel_slot = (auto_active && (state_r != rsf_pkg::SRC_STATIC))
                    ? cur_cfg.alt_ratio_pointer
                    : mode_r;

  // 20.12 only on the dynamic path, never with the reference absent in auto
  assign wide_active = wide_ratio_format_sel_r && dyn_sel
                    && !(auto_active && !ref_present);

  // the shift works on the registered copy so stored slots never change
  always_comb begin
    scaled_ratio = slot_ratio;
    if (scaler_en) begin
      case (cur_cfg.ratio_scale_sel)
        2'h0: scaled_ratio = {1'b0, slot_ratio[31:1]};
        2'h1: scaled_ratio = {2'h0, slot_ratio[31:2]};
        2'h2: scaled_ratio = {3'h0, slot_ratio[31:3]};
        2'h3: scaled_ratio = {4'h0, slot_ratio[31:4]};
        default: scaled_ratio = slot_ratio;
      endcase
    end
  end

  // the divider setting is applied downstream, so the ratio is not corrected here
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      effective_ratio <= rsf_pkg::RATIO_RESET;
      ratio_wide_fmt  <= 1'b0;
      frac_value      <= rsf_pkg::RATIO_RESET;
      frac_is_dynamic <= 1'b0;
      pll_unlock_hold <= 1'b0;
    end else begin
      effective_ratio <= scaled_ratio;
      ratio_wide_fmt  <= wide_active;
      frac_value      <= dyn_sel ? dpll_ratio : scaled_ratio;
      frac_is_dynamic <= dyn_sel;
      pll_unlock_hold <= (state_nxt == rsf_pkg::SRC_HOLD);
    end
  end

  assign status = '{src_state: state_r, scaler_en: scaler_en, wide_active: wide_active,
                    unlock_hold: pll_unlock_hold, auto_active: auto_active,
                    dynamic_sel: frac_is_dynamic, ref_present: ref_present};

endmodule : rsf_ratio_select

/* File: hdl/rsf_ratio_store.sv */
// Purpose: four-slot user ratio store with two registered read ports
// Assumes: single write port from the register bus
// Notes:   port a feeds the ratio path, port b the bus read-back
`timescale 1ns/1ps
module rsf_ratio_store (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          wr_en,
  input  wire logic [rsf_pkg::SLOT_W-1:0]    wr_slot,
  input  wire logic [rsf_pkg::RATIO_W-1:0]   wr_data,
  input  wire logic [rsf_pkg::SLOT_W-1:0]    rd_slot_a,
  output logic      [rsf_pkg::RATIO_W-1:0]   rd_data_a,
  input  wire logic [rsf_pkg::SLOT_W-1:0]    rd_slot_b,
  output logic      [rsf_pkg::RATIO_W-1:0]   rd_data_b
);

  logic [rsf_pkg::RATIO_W-1:0] slot_r [rsf_pkg::SLOT_N];

  genvar g;
  generate
    for (g = 0; g < rsf_pkg::SLOT_N; g++) begin : g_slot
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          slot_r[g] <= rsf_pkg::RATIO_RESET;
        end else if (wr_en && (wr_slot == rsf_pkg::SLOT_W'(g))) begin
          slot_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // match the slot reset so the ratio path shows no zero dip after release
      rd_data_a <= rsf_pkg::RATIO_RESET;
      rd_data_b <= rsf_pkg::RATIO_RESET;
    end else begin
      rd_data_a <= slot_r[rd_slot_a];
      rd_data_b <= slot_r[rd_slot_b];
    end
  end

endmodule : rsf_ratio_store
